// >>> shared/autodisc_defs.vh
// constants for the serial autodisconnect control block
// Operation
// - two causes latch halt until cleared
// - enabled handshake input false enters halt
// - enables set by register or command
// - overrun when receive cannot store character
// - overrun shown in status bit five
// - halted: no data either side
// - halt drives uncommanded handshake outputs false
// - halt entry flushes both buffers
// - only device clear or reset resumes
// - both enables: receive data raises request
`ifndef AUTODISC_DEFS_VH
`define AUTODISC_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_IRQ_STAT   8'h08
`define OFF_IRQ_MASK   8'h0C
`define OFF_HS_OUT     8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_EN_LSB    0
`define CTRL_EN_MSB    2
`define CTRL_SRQ_A     3
`define CTRL_SRQ_B     4
`define ST_HALTED      0
`define ST_CAUSE_LINE  1
`define ST_CAUSE_OVR   2
`define ST_OVERRUN     5
`define ST_LINES_LSB   8
`define ST_LINES_MSB   10
`define HS_LVL_LSB     0
`define HS_LVL_MSB     2
`define HS_DIR_LSB     4
`define HS_DIR_MSB     6
`define EV_HALT        0
`define EV_OVERRUN     1
`define EV_RXDATA      2
`define EV_W           3

// ----------------------------------------
// reset values and bus answers
// ----------------------------------------
`define RST_CTRL       3'h0
`define RST_HS_LVL     3'h7
`define RST_HS_DIR     3'h0
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// >>> core/hs_sync.v
// two-flop synchroniser and false-level detect for handshake inputs
`timescale 1ns/1ps
module hs_sync #(
	parameter N = 3
) (
	// clock and reset
	input  wire         aclk,
	input  wire         aresetn,
	// raw lines and enables
	input  wire [N-1:0] line_raw,
	input  wire [N-1:0] line_enable,
	// synchronised levels and enabled-false flag
	output wire [N-1:0] line_sync,
	output reg          line_fault
);
	reg [N-1:0] meta_q;
	reg [N-1:0] sync_q;

	// meta_q feeds only sync_q
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_q     <= {N{1'b1}};
			sync_q     <= {N{1'b1}};
			line_fault <= 1'b0;
		end else begin
			meta_q     <= line_raw;
			sync_q     <= meta_q;
			line_fault <= |(line_enable & ~sync_q);
		end
	end

	assign line_sync = sync_q;
endmodule // hs_sync

// >>> core/srq_gen.v
// service request on received serial data
`timescale 1ns/1ps
module srq_gen (
	// clock and reset
	input  wire aclk,
	input  wire aresetn,
	// conditions
	input  wire enable_a,
	input  wire enable_b,
	input  wire rx_char,
	input  wire halted,
	input  wire poll_ack,
	// request level
	output reg  srq
);
	wire set_srq = enable_a & enable_b & rx_char & ~halted;

	// set wins over the acknowledge
	always @(posedge aclk) begin
		if (!aresetn)
			srq <= 1'b0;
		else if (set_srq)
			srq <= 1'b1;
		else if (poll_ack)
			srq <= 1'b0;
	end
endmodule // srq_gen

// >>> core/serial_autodisconnect_control.v
// autodisconnect fault logic with AXI4-Lite register access
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "autodisc_defs.vh"
module serial_autodisconnect_control (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// loop side
	input  wire        device_clear,
	input  wire        disconnect_enable_command,
	input  wire [2:0]  disconnect_enable_data,
	input  wire        poll_ack,
	output reg         loop_xfer_enable,
	output reg         service_request,
	// serial side: inputs dsr, rlsd, cts in bits 0..2
	input  wire [2:0]  hs_in,
	input  wire        rx_char_strobe,
	input  wire        rx_buf_full,
	output reg  [2:0]  hs_out,
	output reg         serial_xfer_enable,
	// buffer flush pulses
	output reg         tx_buf_flush,
	output reg         rx_buf_flush,
	// interrupt
	output reg         irq
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	reg [2:0]         disconnect_line_enable_control_q;
	reg               receive_srq_enable_a_q;
	reg               receive_srq_enable_b_q;
	reg [2:0]         hs_lvl_q;
	reg [2:0]         hs_dir_q;
	reg [`EV_W-1:0]   irq_stat_q;
	reg [`EV_W-1:0]   irq_mask_q;
	reg               halted_q;
	reg               cause_line_q;
	reg               cause_ovr_q;
	reg               overrun_q;

	// ----------------------------------------
	// bus holding state
	// ----------------------------------------
	reg               aw_hold_q;
	reg [7:0]         aw_addr_q;
	reg               w_hold_q;
	reg [31:0]        w_data_q;
	reg [3:0]         w_strb_q;

	wire [2:0] line_sync;
	wire       line_fault;
	wire       srq_w;

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	hs_sync #(
		.N (3)
	) u_sync (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.line_raw    (hs_in),
		.line_enable (disconnect_line_enable_control_q),
		.line_sync   (line_sync),
		.line_fault  (line_fault)
	);

	srq_gen u_srq (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.enable_a (receive_srq_enable_a_q),
		.enable_b (receive_srq_enable_b_q),
		.rx_char  (rx_char_strobe),
		.halted   (halted_q),
		.poll_ack (poll_ack),
		.srq      (srq_w)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// one-hot register select, shared by read and write
	function [4:0] reg_sel;
		input [7:0] a;
		begin
			case (a)
				`OFF_CTRL:     reg_sel = 5'h01;
				`OFF_STATUS:   reg_sel = 5'h02;
				`OFF_IRQ_STAT: reg_sel = 5'h04;
				`OFF_IRQ_MASK: reg_sel = 5'h08;
				`OFF_HS_OUT:   reg_sel = 5'h10;
				default:       reg_sel = 5'h00;
			endcase
		end
	endfunction

	wire       wr_go  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	wire [4:0] wr_sel = reg_sel(aw_addr_q);
	wire [4:0] rd_sel = reg_sel(s_axi_araddr);
	wire       rd_go  = s_axi_arvalid & s_axi_arready;
	wire       wr_lo  = wr_go & w_strb_q[0];

	// ----------------------------------------
	// fault detection
	// ----------------------------------------
	wire overrun_ev = rx_char_strobe & rx_buf_full & ~halted_q;
	wire fault      = line_fault | overrun_ev;
	wire enter_halt = fault & ~halted_q;
	wire rx_ev      = rx_char_strobe & ~halted_q;

	wire [`EV_W-1:0] ev_set;
	assign ev_set[`EV_HALT]    = enter_halt;
	assign ev_set[`EV_OVERRUN] = overrun_ev;
	assign ev_set[`EV_RXDATA]  = rx_ev;

	// ----------------------------------------
	// halt state and causes
	// ----------------------------------------
	// a fault in the clear cycle wins, so a line still false re-halts
	always @(posedge aclk) begin
		if (!aresetn) begin
			halted_q     <= 1'b0;
			cause_line_q <= 1'b0;
			cause_ovr_q  <= 1'b0;
			overrun_q    <= 1'b0;
		end else begin
			if (fault)
				halted_q <= 1'b1;
			else if (device_clear)
				halted_q <= 1'b0;
			if (enter_halt)
				cause_line_q <= line_fault;
			else if (device_clear)
				cause_line_q <= 1'b0;
			if (enter_halt)
				cause_ovr_q <= overrun_ev;
			else if (device_clear)
				cause_ovr_q <= 1'b0;
			if (overrun_ev)
				overrun_q <= 1'b1;
			else if (device_clear)
				overrun_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// the loop command wins over a bus write in the same cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			disconnect_line_enable_control_q <= `RST_CTRL;
			receive_srq_enable_a_q           <= 1'b0;
			receive_srq_enable_b_q           <= 1'b0;
			hs_lvl_q                         <= `RST_HS_LVL;
			hs_dir_q                         <= `RST_HS_DIR;
			irq_mask_q                       <= {`EV_W{1'b0}};
		end else begin
			if (disconnect_enable_command)
				disconnect_line_enable_control_q <= disconnect_enable_data;
			else if (wr_lo & wr_sel[0])
				disconnect_line_enable_control_q <= w_data_q[`CTRL_EN_MSB:`CTRL_EN_LSB];
			if (wr_lo & wr_sel[0]) begin
				receive_srq_enable_a_q <= w_data_q[`CTRL_SRQ_A];
				receive_srq_enable_b_q <= w_data_q[`CTRL_SRQ_B];
			end
			if (wr_lo & wr_sel[3])
				irq_mask_q <= w_data_q[`EV_W-1:0];
			if (wr_lo & wr_sel[4]) begin
				hs_lvl_q <= w_data_q[`HS_LVL_MSB:`HS_LVL_LSB];
				hs_dir_q <= w_data_q[`HS_DIR_MSB:`HS_DIR_LSB];
			end
		end
	end

	// ----------------------------------------
	// interrupt status, write one to clear
	// ----------------------------------------
	wire [`EV_W-1:0] w1c = (wr_lo & wr_sel[2]) ? w_data_q[`EV_W-1:0] : {`EV_W{1'b0}};

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= {`EV_W{1'b0}};
			irq        <= 1'b0;
		end else begin
			irq_stat_q <= ev_set | (irq_stat_q & ~w1c);
			irq        <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ----------------------------------------
	// side effects of halt
	// ----------------------------------------
	wire halt_now = halted_q | fault;

	always @(posedge aclk) begin
		if (!aresetn) begin
			loop_xfer_enable   <= 1'b0;
			serial_xfer_enable <= 1'b0;
			hs_out             <= 3'h0;
			tx_buf_flush       <= 1'b0;
			rx_buf_flush       <= 1'b0;
			service_request    <= 1'b0;
		end else begin
			loop_xfer_enable   <= ~halt_now;
			serial_xfer_enable <= ~halt_now;
			hs_out             <= halt_now ? (hs_lvl_q & hs_dir_q) : hs_lvl_q;
			tx_buf_flush       <= enter_halt;
			rx_buf_flush       <= enter_halt;
			service_request    <= srq_w;
		end
	end

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	// one write in flight; address and data accepted in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_hold_q      <= 1'b0;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_hold_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (~aw_hold_q & ~s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_hold_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (~w_hold_q & ~s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_go) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (|wr_sel) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	reg [31:0] rd_val;

	always @* begin
		rd_val = 32'h00000000;
		case (1'b1)
			rd_sel[0]: begin
				rd_val[`CTRL_EN_MSB:`CTRL_EN_LSB] = disconnect_line_enable_control_q;
				rd_val[`CTRL_SRQ_A]               = receive_srq_enable_a_q;
				rd_val[`CTRL_SRQ_B]               = receive_srq_enable_b_q;
			end
			rd_sel[1]: begin
				rd_val[`ST_HALTED]                  = halted_q;
				rd_val[`ST_CAUSE_LINE]              = cause_line_q;
				rd_val[`ST_CAUSE_OVR]               = cause_ovr_q;
				rd_val[`ST_OVERRUN]                 = overrun_q;
				rd_val[`ST_LINES_MSB:`ST_LINES_LSB] = line_sync;
			end
			rd_sel[2]: rd_val[`EV_W-1:0] = irq_stat_q;
			rd_sel[3]: rd_val[`EV_W-1:0] = irq_mask_q;
			rd_sel[4]: begin
				rd_val[`HS_LVL_MSB:`HS_LVL_LSB] = hs_lvl_q;
				rd_val[`HS_DIR_MSB:`HS_DIR_LSB] = hs_dir_q;
			end
			default: rd_val = 32'h00000000;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= (|rd_sel) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
			end else if (~s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // serial_autodisconnect_control

// >>> verif/autodisc_assertions.sv
// port checker for the autodisconnect block
`timescale 1ns/1ps
`include "autodisc_defs.vh"
module autodisc_assertions (
	// clock and reset
	input logic        aclk,
	input logic        aresetn,
	// register bus
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [1:0]  s_axi_bresp,
	input logic [7:0]  s_axi_araddr,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic [1:0]  s_axi_rresp,
	input logic [31:0] s_axi_rdata,
	// fault side
	input logic        device_clear,
	input logic        rx_char_strobe,
	input logic        rx_buf_full,
	input logic        loop_xfer_enable,
	input logic        serial_xfer_enable,
	input logic        service_request,
	input logic        tx_buf_flush,
	input logic        rx_buf_flush
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence halt_entry;
		tx_buf_flush;
	endsequence
	sequence no_clear_4;
		(!device_clear) [*4];
	endsequence
	AST_FLUSH_ONCE: assert property (halt_entry |=> !tx_buf_flush && !rx_buf_flush)
		else $error("flush pulse too long");
	AST_HALT_QUIET: assert property (halt_entry |-> rx_buf_flush && !loop_xfer_enable && !serial_xfer_enable)
		else $error("halt entry not quiet");
	AST_HALT_HOLD: assert property (halt_entry ##0 no_clear_4 |-> !serial_xfer_enable && !loop_xfer_enable)
		else $error("halt left without clear");
	AST_OVERRUN_HALT: assert property (rx_char_strobe && rx_buf_full && serial_xfer_enable |=> tx_buf_flush)
		else $error("overrun did not halt");
	AST_SRQ_CAUSE: assert property ($rose(service_request) |-> $past(rx_char_strobe, 2))
		else $error("request without received data");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_R_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFF_HS_OUT
		|=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
endmodule // autodisc_assertions

// >>> verif/serial_far_end.sv
// far-end serial equipment model
`timescale 1ns/1ps
module serial_far_end (
	// clock
	input logic        aclk,
	// bench commands
	input logic [2:0]  drop,
	input logic        send,
	input logic        full,
	// toward the block
	output logic [2:0] hs_in,
	output logic       rx_char_strobe,
	output logic       rx_buf_full
);
	initial begin
		hs_in = 3'h7;
		rx_char_strobe = 0;
		rx_buf_full = 0;
	end
	always @(posedge aclk) begin
		hs_in <= ~drop;
		rx_char_strobe <= send;
		rx_buf_full <= full;
	end
endmodule // serial_far_end

// >>> verif/serial_autodisconnect_control_tb.sv
// bench for the autodisconnect block
`timescale 1ns/1ps
`include "autodisc_defs.vh"
module serial_autodisconnect_control_tb;
	// ----
	// signals
	// ----
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 32'h0, rdv;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        device_clear = 0, disconnect_enable_command = 0, poll_ack = 0, send = 0, full = 0;
	logic [2:0]  disconnect_enable_data = 3'h0, drop = 3'h0;
	logic [1:0]  resp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire         loop_xfer_enable, service_request, serial_xfer_enable, tx_buf_flush, rx_buf_flush;
	wire [2:0]   hs_in, hs_out;
	wire         rx_char_strobe, rx_buf_full;
	int          mismatches = 0, n_tests = 0, cycles = 0;

	always #5 aclk = ~aclk;

	serial_autodisconnect_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.device_clear, .disconnect_enable_command, .disconnect_enable_data, .poll_ack, .loop_xfer_enable,
		.service_request, .hs_in, .rx_char_strobe, .rx_buf_full, .hs_out, .serial_xfer_enable,
		.tx_buf_flush, .rx_buf_flush, .irq);
	serial_far_end far (.aclk, .drop, .send, .full, .hs_in, .rx_char_strobe, .rx_buf_full);

	// ----
	// helpers
	// ----
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up;
		end
	end
	// no local limit: a hung answer is ended by the cycle ceiling
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
		resp = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
		rdv = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task clear_pulse;
		@(posedge aclk);
		device_clear <= 1;
		@(posedge aclk);
		device_clear <= 0;
		repeat (3) @(posedge aclk);
	endtask
	task halt_wait(output int nf);
		nf = 0;
		repeat (10) begin
			@(posedge aclk);
			if (tx_buf_flush === 1'b1) nf++;
		end
	endtask
	task pulse_cmd(input logic [2:0] d);
		@(posedge aclk);
		disconnect_enable_command <= 1;
		disconnect_enable_data <= d;
		@(posedge aclk);
		disconnect_enable_command <= 0;
	endtask

	// ----
	// scenarios
	// ----
	task t_regs;
		chk("enables", {loop_xfer_enable, serial_xfer_enable}, 2'b11);
		chk("hs_out", hs_out, 3'h7);
		rd(`OFF_CTRL);
		chk("ctrl", rdv, 32'h0);
		rd(`OFF_HS_OUT);
		chk("hs reg", rdv, 32'h7);
		rd(`OFF_IRQ_MASK);
		chk("mask", rdv, 32'h0);
		rd(8'h40);
		chk("rd unmapped", resp, `RESP_SLVERR);
		wr(8'h40, 32'h1F);
		chk("wr unmapped", resp, `RESP_SLVERR);
	endtask
	task t_lines;
		int nf;
		for (int i = 0; i < 3; i++) begin
			drop <= 3'h1 << i;
			halt_wait(nf);
			chk("no halt", serial_xfer_enable, 1'b1);
			drop <= 3'h0;
			repeat (5) @(posedge aclk);
			wr(`OFF_CTRL, 32'h1 << i);
			drop <= 3'h1 << i;
			halt_wait(nf);
			chk("flush once", nf, 1);
			chk("halted", {loop_xfer_enable, serial_xfer_enable}, 2'b00);
			chk("hs false", hs_out, 3'h0);
			chk("irq masked", irq, 1'b0);
			rd(`OFF_STATUS);
			chk("status", rdv[2:0], 3'h3);
			drop <= 3'h0;
			repeat (5) @(posedge aclk);
			clear_pulse;
			chk("resumed", {loop_xfer_enable, serial_xfer_enable}, 2'b11);
		end
		wr(`OFF_CTRL, 32'h0);
	endtask
	task t_cmd;
		int nf;
		// line 0 under direct control keeps its level through the halt
		wr(`OFF_HS_OUT, 32'h17);
		pulse_cmd(3'h4);
		drop <= 3'h4;
		halt_wait(nf);
		chk("cmd halt", serial_xfer_enable, 1'b0);
		chk("commanded", hs_out, 3'h1);
		clear_pulse;
		chk("clear refused", loop_xfer_enable, 1'b0);
		drop <= 3'h0;
		repeat (5) @(posedge aclk);
		clear_pulse;
		chk("cmd resume", loop_xfer_enable, 1'b1);
		chk("hs back", hs_out, 3'h7);
		pulse_cmd(3'h0);
		wr(`OFF_HS_OUT, 32'h07);
	endtask
	task t_ovr;
		wr(`OFF_IRQ_MASK, 32'h2);
		@(posedge aclk);
		send <= 1;
		full <= 1;
		@(posedge aclk);
		send <= 0;
		repeat (4) @(posedge aclk);
		chk("ovr halt", serial_xfer_enable, 1'b0);
		chk("irq", irq, 1'b1);
		// halt, overrun and the received character all land in one cycle
		rd(`OFF_IRQ_STAT);
		chk("irq stat", rdv, 32'h7);
		rd(`OFF_STATUS);
		chk("ovr status", {rdv[5], rdv[2], rdv[0]}, 3'h7);
		full <= 0;
		wr(`OFF_IRQ_STAT, 32'h7);
		repeat (2) @(posedge aclk);
		chk("irq clear", irq, 1'b0);
		clear_pulse;
		rd(`OFF_STATUS);
		chk("ovr cleared", rdv[5], 1'b0);
		wr(`OFF_IRQ_MASK, 32'h0);
	endtask
	task t_srq;
		for (int k = 0; k < 2; k++) begin
			wr(`OFF_CTRL, k ? 32'h18 : 32'h08);
			@(posedge aclk);
			send <= 1;
			@(posedge aclk);
			send <= 0;
			repeat (4) @(posedge aclk);
			chk("srq", service_request, k);
			@(posedge aclk);
			poll_ack <= 1;
			@(posedge aclk);
			poll_ack <= 0;
			repeat (3) @(posedge aclk);
			chk("srq off", service_request, 1'b0);
		end
		wr(`OFF_CTRL, 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
		t_regs;
		t_lines;
		t_cmd;
		t_ovr;
		t_srq;
		wrap_up;
	end
endmodule // serial_autodisconnect_control_tb

bind serial_autodisconnect_control autodisc_assertions chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .device_clear, .rx_char_strobe, .rx_buf_full,
	.loop_xfer_enable, .serial_xfer_enable, .service_request, .tx_buf_flush, .rx_buf_flush);
